// *** scm_ctrl.sv ***
// system clock select and operating mode controller
// assumes oscillator outputs arrive asynchronously as slow square waves
// and halt/wake requests are single-cycle strobes from the core
`timescale 1ns/1ps

module scm_ctrl (
    // clock and reset
    input  wire logic       i_clk_sys,
    input  wire logic       i_reset_n,
    // register port
    input  wire logic [3:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata,
    // oscillator inputs, asynchronous
    input  wire logic       i_fast_osc,
    input  wire logic       i_crystal_osc,
    input  wire logic       i_slow_rc_osc,
    // core events
    input  wire logic       i_halt,
    input  wire logic       i_wake,
    // oscillator enables
    output logic            o_fast_osc_en,
    output logic            o_crystal_en,
    output logic            o_slow_rc_en,
    // clock gates and status
    output logic            o_cpu_run,
    output logic            o_sys_clk_en,
    output logic            o_fast_clk_en,
    output logic            o_sub_clk_en,
    output logic            o_sys_tick,
    output logic            o_switch_busy,
    output logic      [2:0] o_mode
);
    typedef struct packed {
        logic [2:0]        sys_clk_sel;
        logic              low_osc_sel;
        logic              fast_osc_keep_on_halt;
        logic              slow_osc_keep_on_halt;
        scm_pkg::scm_mode_e mode;
        logic [2:0]        sy_fast;
        logic [2:0]        sy_xtal;
        logic [2:0]        sy_lrc;
        logic              fast_lvl;
        logic              sub_lvl;
        logic              fast_tick;
        logic              sub_tick;
        logic              sw_start;
        logic [7:0]        rdata;
        logic              fast_en;
        logic              sys_en;
        logic              sub_en;
    } scm_ctrl_s;

    scm_ctrl_s st_r;
    scm_ctrl_s st_nxt;

    scm_clk_if cif ();

    // core-running mode for a select code
    function automatic scm_pkg::scm_mode_e run_mode(input logic [2:0] s);
        run_mode = (s == scm_pkg::SEL_SUB) ? scm_pkg::SCM_SLOW
                                           : scm_pkg::SCM_FAST;
    endfunction

    function automatic logic is_run(input scm_pkg::scm_mode_e m);
        is_run = (m == scm_pkg::SCM_FAST) || (m == scm_pkg::SCM_SLOW);
    endfunction

    logic       sub_src;
    logic [7:0] ctrl_img;
    logic [7:0] stat_img;

    always_comb begin
        st_nxt = st_r;
        // three-stage sync; a change counts when stages two and three agree
        st_nxt.sy_fast = {st_r.sy_fast[1:0], i_fast_osc};
        st_nxt.sy_xtal = {st_r.sy_xtal[1:0], i_crystal_osc};
        st_nxt.sy_lrc  = {st_r.sy_lrc[1:0], i_slow_rc_osc};
        st_nxt.fast_tick = 1'b0;
        st_nxt.sub_tick  = 1'b0;
        st_nxt.sw_start  = 1'b0;
        if (st_r.sy_fast[2] == st_r.sy_fast[1]) begin
            st_nxt.fast_lvl  = st_r.sy_fast[2];
            st_nxt.fast_tick = st_r.sy_fast[2] & ~st_r.fast_lvl
                               & st_r.fast_en;
        end
        if (st_r.low_osc_sel) begin
            if (st_r.sy_xtal[2] == st_r.sy_xtal[1]) begin
                st_nxt.sub_lvl  = st_r.sy_xtal[2];
                st_nxt.sub_tick = st_r.sy_xtal[2] & ~st_r.sub_lvl;
            end
        end else if (st_r.sy_lrc[2] == st_r.sy_lrc[1]) begin
            st_nxt.sub_lvl  = st_r.sy_lrc[2];
            st_nxt.sub_tick = st_r.sy_lrc[2] & ~st_r.sub_lvl;
        end
        if (!st_r.sub_en) begin
            st_nxt.sub_tick = 1'b0;
        end

        // register writes
        if (i_wr && i_addr == scm_pkg::ADDR_CLK_CTRL) begin
            st_nxt.sys_clk_sel =
                i_wdata[scm_pkg::SEL_MSB:scm_pkg::SEL_LSB];
            st_nxt.low_osc_sel = i_wdata[scm_pkg::LOW_SEL_BIT];
            st_nxt.fast_osc_keep_on_halt = i_wdata[scm_pkg::FAST_KEEP_BIT];
            st_nxt.slow_osc_keep_on_halt = i_wdata[scm_pkg::SLOW_KEEP_BIT];
            st_nxt.sw_start =
                (i_wdata[scm_pkg::SEL_MSB:scm_pkg::SEL_LSB]
                 != st_r.sys_clk_sel)
                || (i_wdata[scm_pkg::LOW_SEL_BIT] != st_r.low_osc_sel);
        end

        case (st_r.mode)
            scm_pkg::SCM_FAST,
            scm_pkg::SCM_SLOW: begin
                if (i_halt) begin
                    case ({st_r.fast_osc_keep_on_halt,
                           st_r.slow_osc_keep_on_halt})
                        2'b00: st_nxt.mode = scm_pkg::SCM_SLEEP;
                        2'b01: st_nxt.mode = scm_pkg::SCM_HALT_SLOW_ONLY_MODE;
                        2'b10: st_nxt.mode = scm_pkg::SCM_HALT_FAST_ONLY_MODE;
                        default: st_nxt.mode = scm_pkg::SCM_HALT_BOTH_OSC_MODE;
                    endcase
                end else begin
                    st_nxt.mode = run_mode(st_nxt.sys_clk_sel);
                end
            end
            scm_pkg::SCM_SLEEP,
            scm_pkg::SCM_HALT_SLOW_ONLY_MODE,
            scm_pkg::SCM_HALT_BOTH_OSC_MODE,
            scm_pkg::SCM_HALT_FAST_ONLY_MODE: begin
                if (i_wake) begin
                    st_nxt.mode = run_mode(st_r.sys_clk_sel);
                end
            end
            default: st_nxt.mode = scm_pkg::SCM_FAST;
        endcase

        // clock gating per mode
        case (st_nxt.mode)
            scm_pkg::SCM_FAST: begin
                st_nxt.fast_en = 1'b1;
                st_nxt.sys_en  = 1'b1;
                st_nxt.sub_en  = 1'b1;
            end
            scm_pkg::SCM_SLOW: begin
                st_nxt.fast_en = st_nxt.fast_osc_keep_on_halt;
                st_nxt.sys_en  = 1'b1;
                st_nxt.sub_en  = 1'b1;
            end
            scm_pkg::SCM_HALT_SLOW_ONLY_MODE: begin
                st_nxt.fast_en = 1'b0;
                st_nxt.sub_en  = 1'b1;
                st_nxt.sys_en  = (st_nxt.sys_clk_sel == scm_pkg::SEL_SUB);
            end
            scm_pkg::SCM_HALT_BOTH_OSC_MODE: begin
                st_nxt.fast_en = 1'b1;
                st_nxt.sub_en  = 1'b1;
                st_nxt.sys_en  = 1'b1;
            end
            scm_pkg::SCM_HALT_FAST_ONLY_MODE: begin
                st_nxt.fast_en = 1'b1;
                st_nxt.sub_en  = (st_nxt.sys_clk_sel == scm_pkg::SEL_SUB);
                st_nxt.sys_en  = (st_nxt.sys_clk_sel != scm_pkg::SEL_SUB);
            end
            // sleep stops all but slow RC
            default: begin
                st_nxt.fast_en = 1'b0;
                st_nxt.sub_en  = 1'b0;
                st_nxt.sys_en  = 1'b0;
            end
        endcase

        // read data, valid the cycle after the strobe
        st_nxt.rdata = 8'h00;
        if (i_rd) begin
            case (i_addr)
                scm_pkg::ADDR_CLK_CTRL: st_nxt.rdata = ctrl_img;
                scm_pkg::ADDR_STATUS:   st_nxt.rdata = stat_img;
                default:                st_nxt.rdata = 8'h00;
            endcase
        end
    end

    always_comb begin
        sub_src  = (st_r.sys_clk_sel == scm_pkg::SEL_SUB);
        ctrl_img = scm_pkg::CTRL_RESET;
        ctrl_img[scm_pkg::SEL_MSB:scm_pkg::SEL_LSB] = st_r.sys_clk_sel;
        ctrl_img[scm_pkg::LOW_SEL_BIT]   = st_r.low_osc_sel;
        ctrl_img[scm_pkg::FAST_KEEP_BIT] = st_r.fast_osc_keep_on_halt;
        ctrl_img[scm_pkg::SLOW_KEEP_BIT] = st_r.slow_osc_keep_on_halt;
        stat_img = 8'h00;
        stat_img[scm_pkg::ST_MODE_LSB +: 3] = st_r.mode;
        stat_img[scm_pkg::ST_BUSY_BIT]      = cif.sw_busy;
        stat_img[scm_pkg::ST_SRC_SUB_BIT]   = sub_src;
        stat_img[scm_pkg::ST_LOW_SRC_BIT]   = st_r.low_osc_sel;
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_r       <= '0;
            st_r.mode  <= scm_pkg::SCM_FAST;
            st_r.fast_en <= 1'b1;
            st_r.sys_en  <= 1'b1;
            st_r.sub_en  <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign cif.fast_tick = st_r.fast_tick;
    assign cif.sub_tick  = st_r.sub_tick;
    assign cif.sel       = st_r.sys_clk_sel;
    assign cif.use_sub   = sub_src;
    assign cif.sw_start  = st_r.sw_start;

    scm_sys_div u_div (
        .i_clk_sys (i_clk_sys),
        .i_reset_n (i_reset_n),
        .bus       (cif.div)
    );

    scm_switch_timer u_sw (
        .i_clk_sys (i_clk_sys),
        .i_reset_n (i_reset_n),
        .bus       (cif.sw)
    );

    assign o_rdata       = st_r.rdata;
    assign o_fast_osc_en = st_r.fast_en;
    assign o_crystal_en  = st_r.low_osc_sel & st_r.sub_en;
    assign o_slow_rc_en  = 1'b1;
    assign o_cpu_run     = is_run(st_r.mode);
    assign o_sys_clk_en  = st_r.sys_en;
    assign o_fast_clk_en = st_r.fast_en;
    assign o_sub_clk_en  = st_r.sub_en;
    assign o_sys_tick    = cif.sys_tick & st_r.sys_en;
    assign o_switch_busy = cif.sw_busy;
    assign o_mode        = st_r.mode;
endmodule

// *** scm_pkg.sv ***
// package for the system clock and operating mode controller
// shared by the controller, its switch-timer module, the checker and the bench
package scm_pkg;

    // clock control register fields
    localparam int unsigned CTRL_ADDR_W     = 4;
    localparam logic [3:0]  ADDR_CLK_CTRL   = 4'h0;
    localparam logic [3:0]  ADDR_STATUS     = 4'h1;
    localparam int unsigned SEL_MSB         = 7;
    localparam int unsigned SEL_LSB         = 5;
    localparam int unsigned LOW_SEL_BIT     = 2;
    localparam int unsigned FAST_KEEP_BIT   = 1;
    localparam int unsigned SLOW_KEEP_BIT   = 0;
    localparam logic [7:0]  CTRL_RESET      = 8'h00;
    localparam logic [2:0]  SEL_SUB         = 3'h7;
    localparam logic [2:0]  SEL_RESET       = 3'h0;

    // status register fields
    localparam int unsigned ST_MODE_LSB     = 0;
    localparam int unsigned ST_BUSY_BIT     = 4;
    localparam int unsigned ST_SRC_SUB_BIT  = 5;
    localparam int unsigned ST_LOW_SRC_BIT  = 6;

    // switch settle: four system clock periods
    localparam int unsigned SWITCH_SYS_PERIODS = 4;
    // source sampling margin in system ticks, added to the settle count (three-stage sync)
    localparam int unsigned SYNC_STAGES     = 3;
    // width of the switch counter
    localparam int unsigned SW_CNT_W        = 4;

    typedef enum logic [2:0] {
        SCM_FAST  = 3'b000,
        SCM_SLOW  = 3'b001,
        SCM_SLEEP = 3'b010,
        SCM_HALT_SLOW_ONLY_MODE = 3'b011,
        SCM_HALT_BOTH_OSC_MODE = 3'b100,
        SCM_HALT_FAST_ONLY_MODE = 3'b101
    } scm_mode_e;

endpackage

// *** scm_clk_if.sv ***
// interface carrying clock enables between the controller and its helpers
// all signals live on i_clk_sys
`timescale 1ns/1ps
interface scm_clk_if;
    logic       fast_tick;
    logic       sub_tick;
    logic [2:0] sel;
    logic       use_sub;
    logic       sys_tick;
    logic       sw_start;
    logic       sw_busy;

    modport ctrl (
        input  sys_tick,
        input  sw_busy,
        output fast_tick,
        output sub_tick,
        output sel,
        output use_sub,
        output sw_start
    );
    modport div (
        input  fast_tick,
        input  sub_tick,
        input  sel,
        input  use_sub,
        output sys_tick
    );
    modport sw (
        input  sys_tick,
        input  sw_start,
        output sw_busy
    );
endinterface

// *** scm_sys_div.sv ***
// system clock tick generator: divided fast ticks or sub-clock ticks
// assumes fast_tick and sub_tick are single-cycle strobes on i_clk_sys
`timescale 1ns/1ps
module scm_sys_div (
    // clock and reset
    input  wire logic i_clk_sys,
    input  wire logic i_reset_n,
    // tick interface
    scm_clk_if.div    bus
);
    typedef struct packed {
        logic [5:0] cnt;
        logic       tick;
    } scm_div_s;

    scm_div_s st_r;
    scm_div_s st_nxt;

    // all-ones mask of the divide ratio for a select code
    function automatic logic [5:0] div_mask(input logic [2:0] s);
        div_mask = 6'(7'h7f >> (3'h7 - s)) ;
    endfunction

    always_comb begin
        st_nxt      = st_r;
        st_nxt.tick = 1'b0;
        if (bus.use_sub) begin
            st_nxt.tick = bus.sub_tick;
            st_nxt.cnt  = 6'h00;
        end else if (bus.fast_tick) begin
            if ((st_r.cnt & div_mask(bus.sel)) == div_mask(bus.sel)) begin
                st_nxt.cnt  = 6'h00;
                st_nxt.tick = 1'b1;
            end else begin
                st_nxt.cnt = st_r.cnt + 6'h01;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign bus.sys_tick = st_r.tick;
endmodule

// *** scm_switch_timer.sv ***
// clock switch settle timer: busy until enough system ticks pass
// assumes sw_start is a one-cycle strobe on each source change
`timescale 1ns/1ps
module scm_switch_timer (
    // clock and reset
    input  wire logic i_clk_sys,
    input  wire logic i_reset_n,
    // timer interface
    scm_clk_if.sw     bus
);
    typedef struct packed {
        logic [scm_pkg::SW_CNT_W-1:0] cnt;
        logic                         busy;
    } scm_sw_s;

    localparam logic [scm_pkg::SW_CNT_W-1:0] SW_LAST =
        scm_pkg::SW_CNT_W'(scm_pkg::SWITCH_SYS_PERIODS
                           + scm_pkg::SYNC_STAGES);

    scm_sw_s st_r;
    scm_sw_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (bus.sw_start) begin
            st_nxt.busy = 1'b1;
            st_nxt.cnt  = '0;
        end else if (st_r.busy && bus.sys_tick) begin
            if (st_r.cnt == SW_LAST) begin
                st_nxt.busy = 1'b0;
            end else begin
                st_nxt.cnt = st_r.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign bus.sw_busy = st_r.busy;
endmodule

// *** scm_ctrl_sva.sv ***
// checker for the clock select and operating mode controller
// assumes it sees the top ports only, on one clock domain
`timescale 1ns/1ps
module scm_ctrl_chk (
    // clock and reset
    input wire logic       i_clk_sys,
    input wire logic       i_reset_n,
    // register port and core events
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic       i_wr,
    input wire logic       i_halt,
    input wire logic       i_wake,
    // observed outputs
    input wire logic       o_slow_rc_en,
    input wire logic       o_cpu_run,
    input wire logic       o_sys_clk_en,
    input wire logic       o_fast_clk_en,
    input wire logic       o_sub_clk_en,
    input wire logic       o_switch_busy,
    input wire logic [2:0] o_mode
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);

    // shadow of the control byte as software wrote it
    logic [7:0] ctrl_r;
    logic [7:0] ctrl_nxt;
    logic       wr_ctrl;
    logic       sub_sel;
    logic [2:0] halt_mode;
    assign wr_ctrl = i_wr && i_addr == scm_pkg::ADDR_CLK_CTRL;
    assign ctrl_nxt = wr_ctrl ? i_wdata : ctrl_r;
    assign sub_sel = ctrl_r[7:5] == scm_pkg::SEL_SUB;
    assign halt_mode = ctrl_r[1] ?
        (ctrl_r[0] ? scm_pkg::SCM_HALT_BOTH_OSC_MODE : scm_pkg::SCM_HALT_FAST_ONLY_MODE) :
        (ctrl_r[0] ? scm_pkg::SCM_HALT_SLOW_ONLY_MODE : scm_pkg::SCM_SLEEP);
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctrl_r <= scm_pkg::CTRL_RESET;
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    slow_rc_on_a: assert property (o_slow_rc_en)
        else $error("slow rc clock stopped");
    cpu_run_mode_a: assert property (o_cpu_run ==
        (o_mode == scm_pkg::SCM_FAST || o_mode == scm_pkg::SCM_SLOW))
        else $error("cpu run disagrees with mode");
    halt_entry_a: assert property (i_halt && o_cpu_run |=>
        o_mode == $past(halt_mode) && !o_cpu_run)
        else $error("halt entered wrong mode");
    wake_resume_a: assert property (i_wake && !o_cpu_run |=> o_cpu_run)
        else $error("wake did not resume");
    sleep_gates_a: assert property (o_mode == scm_pkg::SCM_SLEEP |->
        !o_sys_clk_en && !o_fast_clk_en && !o_sub_clk_en)
        else $error("sleep gates wrong");
    halt_slow_only_mode_gates_a: assert property (o_mode == scm_pkg::SCM_HALT_SLOW_ONLY_MODE |->
        !o_fast_clk_en && o_sub_clk_en && o_sys_clk_en == sub_sel)
        else $error("halt_slow_only_mode gates wrong");
    halt_both_osc_mode_gates_a: assert property (o_mode == scm_pkg::SCM_HALT_BOTH_OSC_MODE |->
        o_sys_clk_en && o_fast_clk_en && o_sub_clk_en)
        else $error("halt_both_osc_mode gates wrong");
    halt_fast_only_mode_gates_a: assert property (o_mode == scm_pkg::SCM_HALT_FAST_ONLY_MODE |->
        o_fast_clk_en && o_sys_clk_en == !sub_sel && o_sub_clk_en == sub_sel)
        else $error("halt_fast_only_mode gates wrong");
    run_gates_a: assert property (o_cpu_run |-> o_sub_clk_en &&
        (o_mode != scm_pkg::SCM_FAST || o_fast_clk_en && o_sys_clk_en))
        else $error("run mode gates wrong");
    mode_follow_a: assert property (wr_ctrl && o_cpu_run && !i_halt |=>
        ##[0:1] o_mode == (sub_sel ? scm_pkg::SCM_SLOW : scm_pkg::SCM_FAST))
        else $error("mode does not follow select");
    busy_start_a: assert property (wr_ctrl &&
        {i_wdata[7:5], i_wdata[2]} != {ctrl_r[7:5], ctrl_r[2]} |=>
        ##1 o_switch_busy)
        else $error("switch busy not raised");

    cover property (o_mode == scm_pkg::SCM_HALT_FAST_ONLY_MODE && sub_sel);
    cover property (i_halt && wr_ctrl && o_cpu_run);
    cover property ($fell(o_switch_busy));
endmodule

bind scm_ctrl scm_ctrl_chk chk (
    .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_halt(i_halt), .i_wake(i_wake),
    .o_slow_rc_en(o_slow_rc_en), .o_cpu_run(o_cpu_run),
    .o_sys_clk_en(o_sys_clk_en), .o_fast_clk_en(o_fast_clk_en),
    .o_sub_clk_en(o_sub_clk_en), .o_switch_busy(o_switch_busy),
    .o_mode(o_mode));

// *** scm_ctrl_tb.sv ***
// self-checking bench for the clock select and mode controller
// drives the register port, halt and wake, and free oscillator inputs
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin \
    miscompares++; $display("Error %s expected %h seen %h", nm, ex, got); \
    end end
module scm_ctrl_tb;
    logic i_clk_sys, i_reset_n, i_wr, i_rd, i_halt, i_wake;
    logic i_fast_osc, i_crystal_osc, i_slow_rc_osc;
    logic [3:0] i_addr;
    logic [7:0] i_wdata, o_rdata, d;
    logic o_fast_osc_en, o_crystal_en, o_slow_rc_en, o_cpu_run;
    logic o_sys_clk_en, o_fast_clk_en, o_sub_clk_en, o_sys_tick;
    logic o_switch_busy;
    logic [2:0] o_mode, em, ex;
    int miscompares, checked, n0, n2, n6;

    scm_ctrl uut (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .i_fast_osc(i_fast_osc),
        .i_crystal_osc(i_crystal_osc), .i_slow_rc_osc(i_slow_rc_osc),
        .i_halt(i_halt), .i_wake(i_wake), .o_fast_osc_en(o_fast_osc_en),
        .o_crystal_en(o_crystal_en), .o_slow_rc_en(o_slow_rc_en),
        .o_cpu_run(o_cpu_run), .o_sys_clk_en(o_sys_clk_en),
        .o_fast_clk_en(o_fast_clk_en), .o_sub_clk_en(o_sub_clk_en),
        .o_sys_tick(o_sys_tick), .o_switch_busy(o_switch_busy),
        .o_mode(o_mode));

    initial begin
        i_clk_sys = 1'b0;
        forever #12.5 i_clk_sys = ~i_clk_sys;
    end
    // oscillators run free, unrelated in phase to the system clock
    always #51 i_fast_osc = ~i_fast_osc;
    always #403 i_crystal_osc = ~i_crystal_osc;
    always #497 i_slow_rc_osc = ~i_slow_rc_osc;

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_wdata <= v;
        i_wr <= 1'b1;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask
    task automatic pulse(input bit h);
        @(posedge i_clk_sys);
        if (h) i_halt <= 1'b1;
        else i_wake <= 1'b1;
        @(posedge i_clk_sys);
        i_halt <= 1'b0;
        i_wake <= 1'b0;
        repeat (2) @(posedge i_clk_sys);
        #1;
    endtask
    task automatic settle;
        int n;
        n = 0;
        // busy rises two edges after the write strobe
        repeat (2) @(posedge i_clk_sys);
        #1;
        while (o_switch_busy !== 1'b0 && n < 5000) begin
            @(posedge i_clk_sys);
            n++;
        end
        `CHK("settle", 1'b1, n < 5000)
    endtask
    task automatic ticks(input logic [7:0] v, output int n);
        wr(4'h0, v);
        settle();
        n = 0;
        repeat (1000) begin
            @(posedge i_clk_sys);
            #1 if (o_sys_tick === 1'b1) n++;
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge i_clk_sys);
        miscompares++;
        close_out();
    end

    initial begin
        {i_reset_n, i_wr, i_rd, i_halt, i_wake, i_addr, i_wdata} = '0;
        {i_fast_osc, i_crystal_osc, i_slow_rc_osc} = '0;
        repeat (8) @(posedge i_clk_sys);
        i_reset_n <= 1'b1;
        rd(4'h0); `CHK("ctrl", 8'h00, d)
        wr(4'h1, 8'hff);
        rd(4'h1); `CHK("status", 8'h00, d)
        rd(4'hf); `CHK("unmapped", 8'h00, d)
        `CHK("slow rc", 1'b1, o_slow_rc_en)
        $display("test reset done");
        for (int s = 0; s < 2; s++) begin
            for (int k = 0; k < 4; k++) begin
                wr(4'h0, {s ? 3'h7 : 3'h0, 3'h0, k[1:0]});
                settle();
                pulse(1);
                em = k == 0 ? scm_pkg::SCM_SLEEP : k == 1 ? scm_pkg::SCM_HALT_SLOW_ONLY_MODE
                   : k == 3 ? scm_pkg::SCM_HALT_BOTH_OSC_MODE : scm_pkg::SCM_HALT_FAST_ONLY_MODE;
                ex = k == 0 ? 3'b000 : k == 1 ? {s[0], 2'b01}
                   : k == 3 ? 3'b111 : {!s[0], 1'b1, s[0]};
                `CHK("mode", em, o_mode)
                `CHK("gates", ex, {o_sys_clk_en, o_fast_clk_en, o_sub_clk_en})
                `CHK("cpu", 1'b0, o_cpu_run)
                pulse(0);
                em = s ? scm_pkg::SCM_SLOW : scm_pkg::SCM_FAST;
                `CHK("resume", em, o_mode)
            end
        end
        $display("test halt table done");
        wr(4'h0, 8'h00);
        settle();
        @(posedge i_clk_sys);
        i_wdata <= 8'h03;
        i_wr <= 1'b1;
        i_halt <= 1'b1;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
        i_halt <= 1'b0;
        @(posedge i_clk_sys);
        #1 `CHK("old keep", 3'(scm_pkg::SCM_SLEEP), o_mode)
        pulse(0);
        pulse(1);
        `CHK("new keep", 3'(scm_pkg::SCM_HALT_BOTH_OSC_MODE), o_mode)
        pulse(0);
        $display("test halt sampling done");
        wr(4'h0, 8'he4);
        settle();
        rd(4'h1); `CHK("status", 8'h61, d)
        `CHK("crystal", 1'b1, o_crystal_en)
        `CHK("fast off", 1'b0, o_fast_osc_en)
        wr(4'h0, 8'he6);
        repeat (2) @(posedge i_clk_sys);
        #1 `CHK("fast on", 1'b1, o_fast_osc_en)
        wr(4'h0, 8'he0);
        settle();
        `CHK("crystal", 1'b0, o_crystal_en)
        rd(4'h0); `CHK("ctrl", 8'he0, d)
        $display("test sub source done");
        wr(4'h0, 8'h00);
        @(posedge i_clk_sys);
        #1 `CHK("busy", 1'b1, o_switch_busy)
        ticks(8'h00, n0);
        ticks(8'h40, n2);
        ticks(8'hc0, n6);
        `CHK("ratio", 1'b1, n0 > 3 * n2 && n0 < 5 * n2)
        `CHK("div64", 1'b1, n6 >= 2 && n6 <= 6)
        $display("test divider done");
        close_out();
    end
endmodule
